/* File: verilog/iswr_pkg.sv */
// Purpose: Shared constants for the image sensor window readout block
// Assumes: 20 MHz system clock, APB register access
// Notes: Offsets are byte addresses of aligned 32-bit words
package iswr_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int FRAME_OVERHEAD_NS = 5000;
  localparam int ROW_OVERHEAD_NS = 200;
  localparam int FOT_CYCLES = (FRAME_OVERHEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROT_CYCLES = (ROW_OVERHEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_W = 10;
  localparam int DAC_W = 7;
  localparam int PIX_W = 10;
  localparam int ADC_LATENCY = 2;
  localparam int CNT_W = 16;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COL_START = 8'h04;
  localparam logic [7:0] OFF_LINE_START = 8'h08;
  localparam logic [7:0] OFF_REF_LEVEL = 8'h0C;
  localparam logic [7:0] OFF_SIZE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam int CTRL_DUAL = 0;
  localparam int CTRL_AVG = 1;
  localparam int CTRL_SNAP = 2;
  localparam int CTRL_NDR = 3;
  localparam int CTRL_OVERLAP = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [9:0] SIZE_RESET = 10'h010;
  localparam logic [7:0] SLVERR_NONE = 8'h00;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FRAME_OH = 5'b00010,
    ST_ROW_OH = 5'b00100,
    ST_PIXELS = 5'b01000,
    ST_DONE = 5'b10000
  } iswr_state_type;
endpackage

/* File: verilog/iswr_adc_pipe.sv */
// Purpose: Two-stage converter pipeline for one column parity
// Assumes: Sample strobe marks the converter clock falling edge
// Notes: Result appears two converter cycles after its sample
`timescale 1ns/1ns
module iswr_adc_pipe (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sample,
  input wire logic [iswr_pkg::PIX_W-1:0] din,
  output logic [iswr_pkg::PIX_W-1:0] dout
);
  import iswr_pkg::*;
  logic [PIX_W-1:0] stage [ADC_LATENCY];
  // Shift on each sample strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage[0] <= '0;
      stage[1] <= '0;
      dout <= '0;
    end else if (sample) begin
      stage[0] <= din;
      stage[1] <= stage[0];
      dout <= stage[1];
    end
  end
endmodule // iswr_adc_pipe

/* File: verilog/iswr_readout.sv */
// Purpose: Window readout sequencer of a global-shutter image sensor
// Assumes: Sync pulses, converter clock and averaging pin arrive asynchronously
// Notes: Pixel values enter as digital samples from the column buses
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
// Operation
// - Frame is overhead plus per-line overhead and pixels
// - Start values load scan registers on sync
// - Window starts advance in steps of two
// - Start address registers are ten bits
// - Start value one means line/column two
// - Single output alternates both column buses
// - Dual outputs run in phase, half rate; here both update every clock, as the single output does
// - Each stage has 7-bit reference level
// - Averaging outputs mean of column pairs
// - Averaging needs pin and config bit
// - Converter samples falling edge, two-cycle latency
// - Even and odd columns use separate converters
// - Two 10-bit converters at 10 MS/s
// - Snapshot resets and samples all pixels together
// - Stored values then read line by line
// - Non-destructive readout reads without reset
// - One bit selects one or two outputs
module iswr_readout (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic col_sync,
  input wire logic line_sync,
  input wire logic adc_clock,
  input wire logic averaging_pin,
  input wire logic [iswr_pkg::PIX_W-1:0] col_bus_even,
  input wire logic [iswr_pkg::PIX_W-1:0] col_bus_odd,
  output logic [iswr_pkg::PIX_W-1:0] pixel_signal_output_a,
  output logic [iswr_pkg::PIX_W-1:0] pixel_signal_output_b,
  output logic [iswr_pkg::DAC_W-1:0] reference_level_output_a,
  output logic [iswr_pkg::DAC_W-1:0] reference_level_output_b,
  output logic pixel_valid,
  output logic [iswr_pkg::ADDR_W:0] col_scan,
  output logic [iswr_pkg::ADDR_W:0] line_scan,
  output logic [iswr_pkg::PIX_W-1:0] adc_even_out,
  output logic [iswr_pkg::PIX_W-1:0] adc_odd_out,
  output logic pixel_reset_all,
  output logic pixel_store_all,
  output logic frame_active
);
  import iswr_pkg::*;

  // Register state
  logic [4:0] ctrl;
  logic [ADDR_W-1:0] col_start;
  logic [ADDR_W-1:0] line_start;
  logic [DAC_W-1:0] ref_level;
  logic [ADDR_W-1:0] win_cols;
  logic [ADDR_W-1:0] win_lines;
  logic [15:0] frame_count;
  logic ndr_reset_done;

  // Synchronisers for pins from outside the clock domain
  logic [1:0] cs_sync;
  logic [1:0] ls_sync;
  logic [1:0] ac_sync;
  logic [1:0] av_sync;
  logic cs_last;
  logic ls_last;
  logic ac_last;

  // Sequencer state
  iswr_state_type state;
  iswr_state_type next_state;
  logic [CNT_W-1:0] timer;
  logic [ADDR_W-1:0] col_left;
  logic [ADDR_W-1:0] line_left;
  logic phase;

  // Decode helper used for every register slot
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // APB decode
  wire apb_access = psel && penable;
  wire apb_write = apb_access && pwrite;
  wire mapped = hit(paddr, OFF_CTRL) || hit(paddr, OFF_COL_START) || hit(paddr, OFF_LINE_START) ||
    hit(paddr, OFF_REF_LEVEL) || hit(paddr, OFF_SIZE) || hit(paddr, OFF_STATUS);
  wire wr_ctrl = apb_write && hit(paddr, OFF_CTRL);
  wire wr_col = apb_write && hit(paddr, OFF_COL_START);
  wire wr_line = apb_write && hit(paddr, OFF_LINE_START);
  wire wr_ref = apb_write && hit(paddr, OFF_REF_LEVEL);
  wire wr_size = apb_write && hit(paddr, OFF_SIZE);

  // Mode decode
  wire dual_mode = ctrl[CTRL_DUAL];
  wire avg_mode = ctrl[CTRL_AVG] && av_sync[1];
  wire snap_mode = ctrl[CTRL_SNAP];
  wire ndr_mode = ctrl[CTRL_NDR];
  wire overlap = ctrl[CTRL_OVERLAP];

  // Edge events on synchronised pins
  wire cs_rise = cs_sync[1] && !cs_last;
  wire ls_rise = ls_sync[1] && !ls_last;
  wire adc_fall = !ac_sync[1] && ac_last;

  // APB answer, zero wait states
  assign pready = 1'b1;
  assign pslverr = apb_access && !mapped;
  wire [31:0] status_word = {frame_count, 9'h000, ndr_reset_done, avg_mode, state};
  assign prdata = hit(paddr, OFF_CTRL) ? {27'h0000000, ctrl} :
    hit(paddr, OFF_COL_START) ? {22'h000000, col_start} :
    hit(paddr, OFF_LINE_START) ? {22'h000000, line_start} :
    hit(paddr, OFF_REF_LEVEL) ? {25'h0000000, ref_level} :
    hit(paddr, OFF_SIZE) ? {6'h00, win_lines, 6'h00, win_cols} :
    hit(paddr, OFF_STATUS) ? status_word : 32'h00000000;

  // Register writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
      col_start <= '0;
      line_start <= '0;
      ref_level <= '0;
      win_cols <= SIZE_RESET;
      win_lines <= SIZE_RESET;
    end else begin
      if (wr_ctrl) ctrl <= pwdata[4:0];
      if (wr_col) col_start <= pwdata[ADDR_W-1:0];
      if (wr_line) line_start <= pwdata[ADDR_W-1:0];
      if (wr_ref) ref_level <= pwdata[DAC_W-1:0];
      if (wr_size) begin
        win_cols <= pwdata[ADDR_W-1:0];
        win_lines <= pwdata[ADDR_W+15:16];
      end
    end
  end

  // Two-flop synchronisers and edge history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_sync <= 2'h0;
      ls_sync <= 2'h0;
      ac_sync <= 2'h0;
      av_sync <= 2'h0;
      cs_last <= 1'b0;
      ls_last <= 1'b0;
      ac_last <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], col_sync};
      ls_sync <= {ls_sync[0], line_sync};
      ac_sync <= {ac_sync[0], adc_clock};
      av_sync <= {av_sync[0], averaging_pin};
      cs_last <= cs_sync[1];
      ls_last <= ls_sync[1];
      ac_last <= ac_sync[1];
    end
  end

  // Sequencer next state
  wire timer_done = (timer == '0);
  wire last_col = (col_left == '0);
  wire last_line = (line_left == '0);
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (ls_rise) next_state = ST_FRAME_OH;
      end
      ST_FRAME_OH: begin
        if (timer_done) next_state = ST_ROW_OH;
      end
      ST_ROW_OH: begin
        if (timer_done) next_state = ST_PIXELS;
      end
      ST_PIXELS: begin
        if (last_col) next_state = last_line ? ST_DONE : ST_ROW_OH;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Columns per line: averaging halves the readout
  wire [ADDR_W-1:0] cols_eff = avg_mode ? {1'b0, win_cols[ADDR_W-1:1]} : win_cols;
  wire [ADDR_W-1:0] cols_m1 = (cols_eff == '0) ? '0 : cols_eff - 1'b1;
  wire [ADDR_W-1:0] lines_m1 = (win_lines == '0) ? '0 : win_lines - 1'b1;
  // Column step: pairs in averaging, two per slot in dual mode
  wire [ADDR_W:0] col_step = (avg_mode || dual_mode) ? 11'h002 : 11'h001;

  // Sequencer registers and scan addresses
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      timer <= '0;
      col_left <= '0;
      line_left <= '0;
      col_scan <= '0;
      line_scan <= '0;
      phase <= 1'b0;
    end else begin
      state <= next_state;
      if (timer != '0) timer <= timer - 1'b1;
      if (ls_rise) begin
        line_scan <= {line_start, 1'b0};
        line_left <= lines_m1;
      end
      if (cs_rise) col_scan <= {col_start, 1'b0};
      case (state)
        ST_IDLE: begin
          if (ls_rise) timer <= CNT_W'(FOT_CYCLES - 1);
        end
        ST_FRAME_OH: begin
          if (timer_done) timer <= CNT_W'(ROT_CYCLES - 1);
        end
        ST_ROW_OH: begin
          col_left <= cols_m1;
          phase <= 1'b0;
        end
        ST_PIXELS: begin
          phase <= !phase;
          col_left <= col_left - 1'b1;
          col_scan <= col_scan + col_step;
          if (last_col) begin
            timer <= CNT_W'(ROT_CYCLES - 1);
            col_scan <= {col_start, 1'b0};
            line_left <= line_left - 1'b1;
            line_scan <= line_scan + 11'h002;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Pixel selection: alternate buses on one output, in phase on two
  wire [PIX_W:0] avg_sum = {1'b0, col_bus_even} + {1'b0, col_bus_odd};
  wire [PIX_W-1:0] avg_val = avg_sum[PIX_W:1];
  wire [PIX_W-1:0] single_val = phase ? col_bus_odd : col_bus_even;
  wire in_pixels = (state == ST_PIXELS);

  // Output stages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pixel_signal_output_a <= '0;
      pixel_signal_output_b <= '0;
      reference_level_output_a <= '0;
      reference_level_output_b <= '0;
      pixel_valid <= 1'b0;
    end else begin
      reference_level_output_a <= ref_level;
      reference_level_output_b <= dual_mode ? ref_level : '0;
      pixel_valid <= in_pixels;
      if (in_pixels) begin
        if (avg_mode) begin
          pixel_signal_output_a <= avg_val;
          pixel_signal_output_b <= dual_mode ? avg_val : '0;
        end else if (dual_mode) begin
          pixel_signal_output_a <= col_bus_even;
          pixel_signal_output_b <= col_bus_odd;
        end else begin
          pixel_signal_output_a <= single_val;
          pixel_signal_output_b <= '0;
        end
      end
    end
  end

  // Snapshot and non-destructive control strobes
  wire frame_start = (state == ST_IDLE) && ls_rise;
  wire frame_end = (state == ST_DONE);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pixel_reset_all <= 1'b0;
      pixel_store_all <= 1'b0;
      frame_count <= '0;
      ndr_reset_done <= 1'b0;
      frame_active <= 1'b0;
    end else begin
      // Done cycle is not part of the frame period
      frame_active <= (next_state != ST_IDLE) && (next_state != ST_DONE);
      // Overlap resets just after the store, else after readout; NONDESTRUCTIVE_READOUT resets once
      pixel_reset_all <= snap_mode && (overlap ? pixel_store_all : frame_end) &&
        !(ndr_mode && ndr_reset_done);
      pixel_store_all <= snap_mode && frame_start;
      if (!ndr_mode) ndr_reset_done <= 1'b0;
      else if (pixel_reset_all) ndr_reset_done <= 1'b1;
      if (frame_end) frame_count <= frame_count + 1'b1;
    end
  end

  // Even and odd column converters
  iswr_adc_pipe u_adc_even (
    .clk(clk),
    .nrst(nrst),
    .sample(adc_fall),
    .din(col_bus_even),
    .dout(adc_even_out)
  );
  iswr_adc_pipe u_adc_odd (
    .clk(clk),
    .nrst(nrst),
    .sample(adc_fall),
    .din(col_bus_odd),
    .dout(adc_odd_out)
  );
endmodule // iswr_readout

/* File: dv/iswr_readout_monitor.sv */
// Purpose: Port checker bound to iswr_readout
// Assumes: Register map of iswr_pkg
// Notes: Shadows written column start and level values
`timescale 1ns/1ns
module iswr_readout_monitor
  import iswr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic col_sync,
  input wire logic [iswr_pkg::ADDR_W:0] col_scan,
  input wire logic [iswr_pkg::ADDR_W:0] line_scan,
  input wire logic [iswr_pkg::DAC_W-1:0] reference_level_output_a,
  input wire logic pixel_reset_all,
  input wire logic pixel_store_all,
  input wire logic frame_active
);
  logic [ADDR_W-1:0] cs;
  logic [DAC_W-1:0] rl;
  logic wr, wr_ref, mapped;
  // Bus decode
  assign wr = psel && penable && pwrite;
  assign wr_ref = wr && paddr == OFF_REF_LEVEL;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= OFF_STATUS;
  // Shadow of column start and reference level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs <= '0;
      rl <= '0;
    end else begin
      if (wr && paddr == OFF_COL_START) cs <= pwdata[ADDR_W-1:0];
      if (wr_ref) rl <= pwdata[DAC_W-1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  col_even_a: assert property (!frame_active |-> col_scan[0] == 1'b0) else $error("odd col scan");
  line_even_a: assert property (line_scan[0] == 1'b0) else $error("odd line scan");
  col_load_a: assert property ($rose(col_sync) && !frame_active |-> ##[1:6] col_scan == {cs, 1'b0})
    else $error("col start not loaded");
  ref_level_a: assert property (!wr_ref && !$past(wr_ref) |-> reference_level_output_a == rl)
    else $error("ref level wrong");
  store_pulse_a: assert property (pixel_store_all |=> !pixel_store_all) else $error("store too long");
  reset_pulse_a: assert property (pixel_reset_all |=> !pixel_reset_all) else $error("reset too long");
  bad_addr_a: assert property (psel && penable && !mapped |-> pslverr) else $error("no slave error");
  good_addr_a: assert property (psel && mapped |-> !pslverr) else $error("false slave error");
  bad_read_a: assert property (psel && penable && !pwrite && !mapped |-> prdata == '0)
    else $error("unmapped read not zero");
  cover property (pixel_store_all);
  cover property (pixel_reset_all);
  cover property (psel && penable && !mapped);
endmodule // iswr_readout_monitor
bind iswr_readout iswr_readout_monitor iswr_readout_monitor_i (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .col_sync(col_sync), .col_scan(col_scan), .line_scan(line_scan),
  .reference_level_output_a(reference_level_output_a), .pixel_reset_all(pixel_reset_all),
  .pixel_store_all(pixel_store_all), .frame_active(frame_active));

/* File: dv/iswr_ctrl_model.sv */
// Purpose: Camera controller model
// Assumes: Bench clock domain
// Notes: Converter clock stands still unless run
`timescale 1ns/1ns
module iswr_ctrl_model #(
  parameter int ADC_HALF = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  output logic col_sync,
  output logic line_sync,
  output logic adc_clock
);
  int cnt;
  initial begin
    col_sync = 1'b0;
    line_sync = 1'b0;
  end
  // Converter clock far below the full pixel rate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      adc_clock <= 1'b0;
    end else if (!run || cnt == ADC_HALF - 1) begin
      cnt <= 0;
      adc_clock <= run && !adc_clock;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Sync pulse of four clocks, sent once setup is written
  task automatic pulse(input bit line);
    if (line) line_sync <= 1'b1;
    else col_sync <= 1'b1;
    repeat (4) @(posedge clk);
    line_sync <= 1'b0;
    col_sync <= 1'b0;
  endtask
endmodule // iswr_ctrl_model

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench for iswr_readout
// Assumes: Zero-wait APB slave
// Notes: Random data from a fixed seed
`timescale 1ns/1ns
module tb_top;
  import iswr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic run = 1'b0;
  logic avg = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [PIX_W-1:0] ce = 10'h000;
  logic [PIX_W-1:0] co = 10'h000;
  logic [31:0] prdata, q, v;
  logic pready, pslverr, col_sync, line_sync, adc_clock, pv, rs, st, fa;
  logic [PIX_W-1:0] pa, pb, ae, ao;
  logic [DAC_W-1:0] ra, rb;
  logic [ADDR_W:0] cscan, lscan;
  int n_fail = 0;
  int cmp_count = 0;
  int n_st, n_rs, n_pv, fa_cnt;
  // Clock of 50 ns
  always #25 clk = ~clk;
  iswr_readout iswr_readout_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .col_sync(col_sync), .line_sync(line_sync), .adc_clock(adc_clock), .averaging_pin(avg),
    .col_bus_even(ce), .col_bus_odd(co), .pixel_signal_output_a(pa), .pixel_signal_output_b(pb),
    .reference_level_output_a(ra), .reference_level_output_b(rb), .pixel_valid(pv),
    .col_scan(cscan), .line_scan(lscan), .adc_even_out(ae), .adc_odd_out(ao),
    .pixel_reset_all(rs), .pixel_store_all(st), .frame_active(fa));
  iswr_ctrl_model iswr_ctrl_model_i (.clk(clk), .nrst(nrst), .run(run), .col_sync(col_sync),
    .line_sync(line_sync), .adc_clock(adc_clock));
  // Count strobes and frame length
  always @(posedge clk) begin
    if (st === 1'b1) n_st <= n_st + 1;
    if (rs === 1'b1) n_rs <= n_rs + 1;
    if (pv === 1'b1) n_pv <= n_pv + 1;
    if (fa === 1'b1) fa_cnt <= fa_cnt + 1;
  end
  task automatic end_of_test;
    $display("compares %0d errors %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    end_of_test;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, read data left in q
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    if (i == 20) hang;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Wait for a falling converter clock
  task automatic fall;
    int i;
    for (i = 0; i < 40 && adc_clock !== 1'b1; i++) @(posedge clk);
    if (i == 40) hang;
    for (i = 0; i < 40 && adc_clock !== 1'b0; i++) @(posedge clk);
    if (i == 40) hang;
  endtask
  // Mean of a column pair, rounded down
  function automatic logic [PIX_W-1:0] mean2(input logic [PIX_W-1:0] a, input logic [PIX_W-1:0] b);
    logic [PIX_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    mean2 = s[PIX_W:1];
  endfunction
  task automatic frame(input int cols, input int lines);
    int i;
    fa_cnt = 0;
    n_pv = 0;
    iswr_ctrl_model_i.pulse(1'b1);
    for (i = 0; i < 20 && fa !== 1'b1; i++) @(posedge clk);
    if (i == 20) hang;
    chk(32'(lscan), 32'h2);
    for (i = 0; i < 3000 && fa === 1'b1; i++) @(posedge clk);
    if (i == 3000) hang;
    repeat (4) @(posedge clk);
    chk(fa_cnt, FOT_CYCLES + lines * (ROT_CYCLES + cols));
    chk(n_pv, lines * cols);
  endtask
  initial begin
    void'($urandom(57));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    run <= 1'b1;
    // Reset values and a refused address
    rdc(OFF_CTRL, 32'h0);
    rdc(OFF_SIZE, {6'h00, SIZE_RESET, 6'h00, SIZE_RESET});
    rdc(OFF_REF_LEVEL, 32'h0);
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    rdc(8'h18, 32'h0);
    // Random starts, level and output mode
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 32'hFFFF_FFFF : $urandom;
      apb(1'b1, OFF_COL_START, v);
      rdc(OFF_COL_START, {22'h0, v[9:0]});
      apb(1'b1, OFF_LINE_START, ~v);
      rdc(OFF_LINE_START, {22'h0, ~v[9:0]});
      apb(1'b1, OFF_CTRL, {31'h0, v[0]});
      apb(1'b1, OFF_REF_LEVEL, v);
      rdc(OFF_REF_LEVEL, {25'h0, v[6:0]});
      chk(32'(ra), {25'h0, v[6:0]});
      chk(32'(rb), {25'h0, v[0] ? v[6:0] : 7'h00});
    end
    // Averaging needs pin and bit together
    for (int k = 0; k < 4; k++) begin
      avg <= k[0];
      apb(1'b1, OFF_CTRL, 32'(k[1]) << CTRL_AVG);
      repeat (4) @(posedge clk);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(32'(q[5]), 32'(k == 3));
    end
    // Converter pipeline, even and odd columns
    for (int k = 0; k < 3; k++) begin
      fall;
      repeat (4) @(posedge clk);
      v = 32'({ce, co});
      ce <= 10'($urandom);
      co <= 10'($urandom);
      fall;
      fall;
      repeat (3) @(posedge clk);
      chk(32'({ae, ao}), v);
      fall;
      repeat (5) @(posedge clk);
      chk(32'({ae, ao}), 32'({ce, co}));
    end
    // Window frames: snapshot, then non-destructive
    apb(1'b1, OFF_SIZE, {6'h00, 10'd2, 6'h00, 10'd4});
    apb(1'b1, OFF_COL_START, 32'h1);
    apb(1'b1, OFF_LINE_START, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1 << CTRL_SNAP);
    iswr_ctrl_model_i.pulse(1'b0);
    repeat (4) @(posedge clk);
    chk(32'(cscan), 32'h2);
    n_st = 0;
    n_rs = 0;
    frame(4, 2);
    chk(n_st, 1);
    chk(n_rs, 1);
    chk(32'(pa), 32'(co));
    chk(32'(pb), 32'h0);
    apb(1'b1, OFF_CTRL, (32'h1 << CTRL_SNAP) | (32'h1 << CTRL_NDR));
    n_st = 0;
    n_rs = 0;
    frame(4, 2);
    frame(4, 2);
    chk(n_st, 2);
    chk(n_rs, 1);
    // Averaged frame with overlapped integration: half the columns
    apb(1'b1, OFF_CTRL, (32'h1 << CTRL_SNAP) | (32'h1 << CTRL_OVERLAP) | (32'h1 << CTRL_AVG));
    n_st = 0;
    n_rs = 0;
    frame(4 / 2, 2);
    chk(n_st, 1);
    chk(n_rs, 1);
    chk(32'(pa), 32'(mean2(ce, co)));
    chk(32'(pb), 32'h0);
    end_of_test;
  end
endmodule // tb_top
